// *** common/mrs_pkg.sv ***
// Register map, field layout, reset values and carrier types of the modem block
package mrs_pkg;
  // Register byte offsets
  localparam logic [5:0] OFF_MODEM_CFG_D = 6'h00;
  localparam logic [5:0] OFF_MODEM_CFG_C = 6'h04;
  localparam logic [5:0] OFF_MODEM_CFG_B = 6'h08;
  localparam logic [5:0] OFF_SYNC_HIGH   = 6'h0C;
  localparam logic [5:0] OFF_SYNC_LOW    = 6'h10;
  localparam logic [5:0] OFF_OFFSET_CFG  = 6'h14;
  localparam logic [5:0] OFF_SYNTH_LOW   = 6'h18;
  localparam logic [5:0] OFF_FREQ_EST    = 6'h1C;
  localparam logic [5:0] OFF_STATUS      = 6'h20;
  localparam logic [5:0] OFF_PQI_CFG     = 6'h24;
  // Reset values
  localparam logic [7:0] RST_CFG_D  = 8'h8C;
  localparam logic [7:0] RST_CFG_C  = 8'h22;
  localparam logic [7:0] RST_CFG_B  = 8'h02;
  localparam logic [7:0] RST_SYNC_H = 8'h5A;
  localparam logic [7:0] RST_SYNC_L = 8'hC3;
  localparam logic [7:0] RST_OCC    = 8'h1E;
  localparam logic [7:0] RST_TRIM   = 8'h00;
  localparam logic [7:0] RST_PQI    = 8'h00;
  // Field positions
  localparam int BWE_LSB  = 6;
  localparam int BWM_LSB  = 4;
  localparam int RE_LSB   = 0;
  localparam int MOD_LSB  = 4;
  localparam int SMODE_LSB = 0;
  localparam int GATE_BIT = 5;
  localparam int PREK_LSB = 3;
  localparam int POSTK_LSB = 1;
  localparam int LIM_BIT  = 0;
  // Encodings and figures
  localparam logic [2:0] MOD_OOK    = 3'h3;
  localparam int unsigned RATE_BASE = 256;
  localparam int unsigned RATE_FRAC = 28;
  localparam int unsigned BW_BASE   = 4;
  localparam int unsigned BW_PRE    = 3;
  localparam int unsigned SYNC_W    = 16;
  localparam logic [5:0] TH_15_16   = 6'd15;
  localparam logic [5:0] TH_16_16   = 6'd16;
  localparam logic [5:0] TH_30_32   = 6'd30;
  localparam logic [4:0] PQI_MAX    = 5'd31;
  localparam logic [4:0] PQI_DROP   = 5'd4;
  localparam int unsigned PQI_STEP  = 2;
  localparam logic [1:0] RESP_OKAY  = 2'b00;
  localparam logic [1:0] RESP_SLV   = 2'b10;

  typedef struct packed {
    logic signed [7:0] freq;
    logic [7:0]        amp;
    logic              carrier_sense;
  } mrs_rx_in_s;

  typedef struct packed {
    logic       bit_val;
    logic       bit_valid;
    logic       sync_found;
    logic [7:0] rx_byte;
    logic       byte_valid;
    logic [7:0] rssi;
  } mrs_rx_out_s;

  typedef enum logic [1:0] {TX_IDLE, TX_SYNC, TX_DATA} mrs_tx_e;
endpackage

// *** design/mrs_rate_nco.sv ***
// Symbol-rate phase accumulator with optional phase nudge
`timescale 1ns/1ps
module mrs_rate_nco #(
  parameter int unsigned ACC_W = 28
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Rate setting
  input  wire logic [7:0] mant,
  input  wire logic [3:0] expo,
  // Phase nudge
  input  wire logic       advance,
  input  wire logic       retard,
  // Outputs
  output logic            tick,
  output logic            late_half
);
  import mrs_pkg::*;

  generate
    if (ACC_W < 25)
      $error("ACC_W too small for the rate range");
  endgenerate

  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] inc;
  logic [ACC_W:0]   sum_nxt;

  // Increment (256 + mantissa) << exponent over 2^ACC_W
  always_comb
  begin
    inc = ACC_W'({1'b1, mant}) << expo;
    sum_nxt = {1'b0, acc_r} + {1'b0, inc};
    if (advance)
      sum_nxt = sum_nxt + {3'b000, inc[ACC_W-1:2]};
    else if (retard)
      sum_nxt = sum_nxt - {3'b000, inc[ACC_W-1:2]};
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      acc_r <= '0;
      tick  <= 1'b0;
    end
    else
    begin
      acc_r <= sum_nxt[ACC_W-1:0];
      tick  <= sum_nxt[ACC_W];
    end
  end

  assign late_half = acc_r[ACC_W-1];
endmodule

// *** design/mrs_modem.sv ***
// Modem rate, channel filter, offset compensation and sync detection with AXI4-Lite registers
`timescale 1ns/1ps

// Behaviour
// - Rates from crystal, (256+mantissa), exponent, 2^28
// - Rate spans about 1.2 to 500 kBaud
// - Filter bandwidth from 8*(4+mantissa)*2^exponent
// - Bandwidth exponent and mantissa are two-bit codes
// - Digital filtering, offset compensation, signal strength
// - Offset estimate readable in frequency estimate register
// - Written offset trim retunes the synthesizer
// - Offset tracking clamped to selectable limit of limit code times 4096, independent of bandwidth
// - Carrier-sense gate freezes compensator until sense
// - Separate tracking gains before and after sync
// - No offset compensation under on-off keying
// - Bit clock recovered and continuously resynchronised
// - 16-bit sync word, repeatable, sent and aligned
// - Search stops at first sync until restart, accepts configured sync word with up to 1 (15/16) or 2 (30/32) bit errors
// - Match thresholds 15/16, 16/16, 30/32
// - Optional preamble quality and carrier qualification
// - Sync word from high and low bytes
// - Sync modes 3 and 7 repeat word
module mrs_modem #(
  parameter int unsigned NCO_W = 28
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset,
  // AXI4-Lite slave
  input  wire logic [5:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [5:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Receive path
  input  wire mrs_pkg::mrs_rx_in_s rx_in,
  input  wire logic                rx_restart,
  output mrs_pkg::mrs_rx_out_s     rx_out,
  // Transmit path
  input  wire logic                tx_start,
  input  wire logic                tx_data,
  output logic                     tx_bit,
  output logic                     tx_data_take,
  // Synthesizer
  output logic [7:0]               synth_offset
);
  import mrs_pkg::*;

  generate
    if (NCO_W != RATE_FRAC)
      $error("NCO_W must match the rate fraction");
  endgenerate

  // Registers
  logic [7:0] cfg_d_r, cfg_c_r, cfg_b_r, sync_h_r, sync_l_r, occ_r, trim_r, pqi_cfg_r;
  logic [1:0] bw_exponent, bw_mantissa, lim_code, pre_k, post_k;
  logic [3:0] rate_exponent;
  logic [7:0] rate_mantissa;
  logic [2:0] sync_mode, mod_fmt, pqi_thr;
  logic       is_ook, cs_gate;

  // Field decode
  assign bw_exponent   = cfg_d_r[BWE_LSB +: 2];
  assign bw_mantissa   = cfg_d_r[BWM_LSB +: 2];
  assign rate_exponent = cfg_d_r[RE_LSB +: 4];
  assign rate_mantissa = cfg_c_r;
  assign mod_fmt       = cfg_b_r[MOD_LSB +: 3];
  assign sync_mode     = cfg_b_r[SMODE_LSB +: 3];
  assign cs_gate       = occ_r[GATE_BIT];
  assign pre_k         = occ_r[PREK_LSB +: 2];
  assign post_k        = occ_r[POSTK_LSB +: 2];
  assign lim_code      = {occ_r[LIM_BIT], occ_r[LIM_BIT+1]};
  assign pqi_thr       = pqi_cfg_r[2:0];
  assign is_ook        = (mod_fmt == MOD_OOK);

  // AXI write channel: address and data taken in either order
  logic       aw_got_r, w_got_r;
  logic [5:0] aw_addr_r;
  logic [7:0] w_data_r;
  logic       w_lane_r;
  logic       wr_fire, wr_ok;

  assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
  always_comb
  begin
    unique case (aw_addr_r)
      OFF_MODEM_CFG_D, OFF_MODEM_CFG_C, OFF_MODEM_CFG_B, OFF_SYNC_HIGH,
      OFF_SYNC_LOW, OFF_OFFSET_CFG, OFF_SYNTH_LOW, OFF_PQI_CFG: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      aw_addr_r     <= '0;
      w_data_r      <= '0;
      w_lane_r      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_got_r && !s_axi_awready;
      s_axi_wready  <= !w_got_r && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_r  <= 1'b1;
        w_data_r <= s_axi_wdata[7:0];
        w_lane_r <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLV;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
      end
    end
  end

  // Register store
  logic wr_en;
  assign wr_en = wr_fire && w_lane_r;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cfg_d_r   <= RST_CFG_D;
      cfg_c_r   <= RST_CFG_C;
      cfg_b_r   <= RST_CFG_B;
      sync_h_r  <= RST_SYNC_H;
      sync_l_r  <= RST_SYNC_L;
      occ_r     <= RST_OCC;
      trim_r    <= RST_TRIM;
      pqi_cfg_r <= RST_PQI;
    end
    else if (wr_en)
    begin
      unique case (aw_addr_r)
        OFF_MODEM_CFG_D: cfg_d_r <= w_data_r;
        OFF_MODEM_CFG_C: cfg_c_r <= w_data_r;
        OFF_MODEM_CFG_B: cfg_b_r <= w_data_r;
        OFF_SYNC_HIGH:   sync_h_r <= w_data_r;
        OFF_SYNC_LOW:    sync_l_r <= w_data_r;
        OFF_OFFSET_CFG:  occ_r <= w_data_r;
        OFF_SYNTH_LOW:   trim_r <= w_data_r;
        OFF_PQI_CFG:     pqi_cfg_r <= w_data_r;
        default:         ;
      endcase
    end
  end

  // Synthesizer retune follows the trim field
  always_ff @(posedge clk)
  begin
    if (reset)
      synth_offset <= RST_TRIM;
    else
      synth_offset <= trim_r;
  end

  // Symbol rate generators
  logic tx_tick, rx_tick, rx_late, nudge_adv, nudge_ret;
  mrs_rate_nco #(.ACC_W(NCO_W)) u_tx_nco (
    .clk       (clk),
    .reset     (reset),
    .mant      (rate_mantissa),
    .expo      (rate_exponent),
    .advance   (1'b0),
    .retard    (1'b0),
    .tick      (tx_tick),
    .late_half ()
  );
  mrs_rate_nco #(.ACC_W(NCO_W)) u_rx_nco (
    .clk       (clk),
    .reset     (reset),
    .mant      (rate_mantissa),
    .expo      (rate_exponent),
    .advance   (nudge_adv),
    .retard    (nudge_ret),
    .tick      (rx_tick),
    .late_half (rx_late)
  );

  // Channel filter: boxcar over (4+M)*2^E samples
  logic [5:0]         decim, fcnt_r;
  logic signed [13:0] fsum_r;
  logic [13:0]        asum_r;
  logic signed [7:0]  filt_r;
  logic               filt_v;
  logic [3:0]         fshift;
  assign decim  = 6'((BW_BASE + 32'(bw_mantissa)) << bw_exponent);
  assign fshift = 4'(32'(bw_exponent) + BW_PRE);
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      fcnt_r      <= '0;
      fsum_r      <= '0;
      asum_r      <= '0;
      filt_r      <= '0;
      filt_v      <= 1'b0;
      rx_out.rssi <= '0;
    end
    else
    begin
      filt_v <= 1'b0;
      if (fcnt_r == decim - 6'd1)
      begin
        fcnt_r      <= '0;
        fsum_r      <= '0;
        asum_r      <= '0;
        filt_r      <= 8'((fsum_r + 14'(rx_in.freq)) >>> fshift);
        rx_out.rssi <= 8'((asum_r + 14'(rx_in.amp)) >> fshift);
        filt_v      <= 1'b1;
      end
      else
      begin
        fcnt_r <= fcnt_r + 6'd1;
        fsum_r <= fsum_r + 14'(rx_in.freq);
        asum_r <= asum_r + 14'(rx_in.amp);
      end
    end
  end

  // Offset estimator with clamp, gate and two gains
  logic signed [15:0] est_r, est_step, est_nxt, lim;
  logic [2:0]         kshift;
  logic               sync_seen_r, freeze;
  assign lim    = 16'(32'(lim_code) << 12);
  assign kshift = 3'({1'b0, sync_seen_r ? post_k : pre_k}) + 3'd1;
  assign freeze = is_ook || (cs_gate && !rx_in.carrier_sense);
  always_comb
  begin
    est_step = ($signed({filt_r, 8'h00}) - est_r) >>> kshift;
    est_nxt  = est_r + est_step;
    if (est_nxt > lim)
      est_nxt = lim;
    else if (est_nxt < -lim)
      est_nxt = -lim;
  end
  always_ff @(posedge clk)
  begin
    if (reset)
      est_r <= '0;
    else if (filt_v && !freeze)
      est_r <= est_nxt;
  end

  // Data decision and bit synchroniser
  logic signed [8:0] comp;
  logic              dec_r;
  assign comp = is_ook ? 9'(rx_out.rssi) - 9'sd128 : 9'(filt_r) - 9'($signed(est_r[15:8]));
  // Decision edges steered towards mid-phase of the receive tick
  assign nudge_adv = filt_v && (!comp[8] != dec_r) && !rx_late;
  assign nudge_ret = filt_v && (!comp[8] != dec_r) && rx_late;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      dec_r            <= 1'b0;
      rx_out.bit_val   <= 1'b0;
      rx_out.bit_valid <= 1'b0;
    end
    else
    begin
      if (filt_v)
        dec_r <= !comp[8];
      rx_out.bit_valid <= rx_tick;
      if (rx_tick)
        rx_out.bit_val <= dec_r;
    end
  end

  // Sync correlator, preamble quality and byte alignment
  function automatic logic [5:0] ones32(input logic [31:0] v);
    logic [5:0] n;
    n = '0;
    for (int i = 0; i < 32; i++)
      n = n + 6'(v[i]);
    return n;
  endfunction

  logic [31:0] rx_sr_r, pat;
  logic [5:0]  hits16, hits32;
  logic [4:0]  pqi_r;
  logic [2:0]  bcnt_r;
  logic        match_ok, pqi_ok, long_sync;
  assign long_sync = (sync_mode[1:0] == 2'd3);
  assign pat    = {sync_h_r, sync_l_r, sync_h_r, sync_l_r};
  assign hits16 = ones32({16'h0000, ~(rx_sr_r[SYNC_W-1:0] ^ pat[SYNC_W-1:0])});
  assign hits32 = ones32(~(rx_sr_r ^ pat));
  always_comb
  begin
    unique case (sync_mode[1:0])
      2'd1: match_ok = hits16 >= TH_15_16;
      2'd2: match_ok = hits16 >= TH_16_16;
      2'd3: match_ok = hits32 >= TH_30_32;
      default: match_ok = 1'b0;
    endcase
    if (sync_mode[2] && !rx_in.carrier_sense)
      match_ok = 1'b0;
  end
  assign pqi_ok = (pqi_thr == 3'd0) || (pqi_r > 5'(32'(pqi_thr) << PQI_STEP));

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rx_sr_r           <= '0;
      pqi_r             <= '0;
      bcnt_r            <= '0;
      sync_seen_r       <= 1'b0;
      rx_out.sync_found <= 1'b0;
      rx_out.rx_byte    <= '0;
      rx_out.byte_valid <= 1'b0;
    end
    else
    begin
      rx_out.sync_found <= 1'b0;
      rx_out.byte_valid <= 1'b0;
      if (rx_restart)
        sync_seen_r <= 1'b0;
      if (rx_out.bit_valid)
      begin
        rx_sr_r <= {rx_sr_r[30:0], rx_out.bit_val};
        if (rx_out.bit_val != rx_sr_r[0])
          pqi_r <= (pqi_r == PQI_MAX) ? PQI_MAX : pqi_r + 5'd1;
        else
          pqi_r <= (pqi_r < PQI_DROP) ? 5'd0 : pqi_r - PQI_DROP;
        bcnt_r <= bcnt_r + 3'd1;
        if (sync_seen_r && bcnt_r == 3'd7)
        begin
          rx_out.rx_byte    <= {rx_sr_r[6:0], rx_out.bit_val};
          rx_out.byte_valid <= 1'b1;
        end
      end
      else if (!sync_seen_r && !rx_restart && match_ok && pqi_ok)
      begin
        sync_seen_r       <= 1'b1;
        rx_out.sync_found <= 1'b1;
        bcnt_r            <= '0;
      end
    end
  end

  // Transmit: sync word inserted ahead of data
  mrs_tx_e     tx_st_r;
  logic [4:0]  tx_cnt_r;
  logic [4:0]  tx_last;
  assign tx_last = long_sync ? 5'd31 : 5'd15;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tx_st_r      <= TX_IDLE;
      tx_cnt_r     <= '0;
      tx_bit       <= 1'b0;
      tx_data_take <= 1'b0;
    end
    else
    begin
      tx_data_take <= 1'b0;
      unique case (tx_st_r)
        TX_IDLE:
          if (tx_start)
          begin
            tx_st_r  <= TX_SYNC;
            tx_cnt_r <= '0;
          end
        TX_SYNC:
          if (tx_tick)
          begin
            tx_bit   <= pat[5'd31 - tx_cnt_r + (long_sync ? 5'd0 : 5'd16)];
            tx_cnt_r <= tx_cnt_r + 5'd1;
            if (tx_cnt_r == tx_last)
              tx_st_r <= TX_DATA;
          end
        TX_DATA:
          if (!tx_start)
            tx_st_r <= TX_IDLE;
          else if (tx_tick)
          begin
            tx_bit       <= tx_data;
            tx_data_take <= 1'b1;
          end
      endcase
    end
  end

  // AXI read channel
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        unique case (s_axi_araddr)
          OFF_MODEM_CFG_D: s_axi_rdata <= {24'h0, cfg_d_r};
          OFF_MODEM_CFG_C: s_axi_rdata <= {24'h0, cfg_c_r};
          OFF_MODEM_CFG_B: s_axi_rdata <= {24'h0, cfg_b_r};
          OFF_SYNC_HIGH:   s_axi_rdata <= {24'h0, sync_h_r};
          OFF_SYNC_LOW:    s_axi_rdata <= {24'h0, sync_l_r};
          OFF_OFFSET_CFG:  s_axi_rdata <= {24'h0, occ_r};
          OFF_SYNTH_LOW:   s_axi_rdata <= {24'h0, trim_r};
          OFF_FREQ_EST:    s_axi_rdata <= {24'h0, est_r[15:8]};
          OFF_STATUS:      s_axi_rdata <= {19'h0, pqi_r, 6'h0, rx_in.carrier_sense, sync_seen_r};
          OFF_PQI_CFG:     s_axi_rdata <= {24'h0, pqi_cfg_r};
          default:
          begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLV;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_trim_write;
    wr_en && aw_addr_r == OFF_SYNTH_LOW;
  endsequence

  a_trim_retune: assert property (s_trim_write |-> ##2 synth_offset == $past(w_data_r, 2))
    else $error("trim not passed to synthesizer");
  a_ook_est_hold: assert property ((is_ook && filt_v) |=> $stable(est_r))
    else $error("estimate moved under on-off keying");
  a_gate_est_hold: assert property ((cs_gate && !rx_in.carrier_sense && filt_v) |=> $stable(est_r))
    else $error("estimate moved while gated");
  a_est_in_limit: assert property (est_r <= lim && est_r >= -lim || $changed(lim))
    else $error("estimate beyond tracking limit");
  a_filter_period: assert property (filt_v |-> $past(fcnt_r == decim - 6'd1))
    else $error("filter output off its decimation period");
  a_sync_qualified: assert property (rx_out.sync_found |-> $past(match_ok && pqi_ok))
    else $error("sync reported without qualified match");
  a_bit_on_tick: assert property (rx_out.bit_valid |-> $past(rx_tick))
    else $error("bit sampled off symbol tick");
  a_tx_sync_len: assert property ((tx_st_r == TX_SYNC) ##1 (tx_st_r == TX_DATA)
    |-> $past(tx_cnt_r) == $past(tx_last))
    else $error("sync word length wrong");
endmodule

// *** test/mrs_air_model.sv ***
// Remote radio over the air: sends transmitted symbols back as receive samples
`timescale 1ns/1ps
module mrs_air_model (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          reset,
  // Air side
  input  wire logic          tx_bit,
  input  wire logic          cs_on,
  output mrs_pkg::mrs_rx_in_s rx_in
);
  import mrs_pkg::*;

  // Deviation well inside the channel filter, centred, carrier as the bench asks
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rx_in <= '0;
    end
    else
    begin
      rx_in.freq          <= tx_bit ? 8'sh28 : 8'shD8;
      rx_in.amp           <= 8'hC8;
      rx_in.carrier_sense <= cs_on;
    end
  end
endmodule

// *** test/tb.sv ***
// Self-checking bench for the modem block with loopback through the air model
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; $display("mismatch t=%0t got %0h exp %0h", $time, g, e); end end
module tb;
  import mrs_pkg::*;
  logic              clk        = 1'b0;
  logic              reset      = 1'b1;
  logic [5:0]        awaddr     = '0;
  logic              awvalid    = 1'b0;
  logic [31:0]       wdata      = '0;
  logic              wvalid     = 1'b0;
  logic              bready     = 1'b0;
  logic [5:0]        araddr     = '0;
  logic              arvalid    = 1'b0;
  logic              rready     = 1'b0;
  logic              rx_restart = 1'b0;
  logic              tx_start   = 1'b0;
  logic              tx_data    = 1'b0;
  logic              awready;
  logic              wready;
  logic [1:0]        bresp;
  logic              bvalid;
  logic              arready;
  logic [31:0]       rdata;
  logic [1:0]        rresp;
  logic              rvalid;
  mrs_rx_in_s        rx_in;
  mrs_rx_out_s       rx_out;
  logic              tx_bit;
  logic              tx_data_take;
  logic [7:0]        synth_offset;
  logic [55:0]       stream     = '0;
  logic [1:0]        r;
  logic [31:0]       d;
  logic [7:0]        trim;
  logic [31:0]       est0;
  logic              cs_on       = 1'b1;
  int                fail_count  = 0;
  int                check_count = 0;
  int                seed        = 13;
  int                cycles      = 0;
  int                sync_cnt    = 0;
  int                bi          = 0;
  logic [5:0]        offs [8] = '{OFF_MODEM_CFG_D, OFF_MODEM_CFG_C, OFF_MODEM_CFG_B, OFF_SYNC_HIGH,
                                  OFF_SYNC_LOW, OFF_OFFSET_CFG, OFF_SYNTH_LOW, OFF_PQI_CFG};
  logic [7:0]        rstv [8] = '{RST_CFG_D, RST_CFG_C, RST_CFG_B, RST_SYNC_H,
                                  RST_SYNC_L, RST_OCC, RST_TRIM, RST_PQI};

  always #5 clk = ~clk;

  mrs_modem u_mrs_modem (
    .clk(clk), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_in(rx_in), .rx_restart(rx_restart), .rx_out(rx_out),
    .tx_start(tx_start), .tx_data(tx_data), .tx_bit(tx_bit), .tx_data_take(tx_data_take),
    .synth_offset(synth_offset)
  );

  mrs_air_model u_mrs_air_model (.clk(clk), .reset(reset), .tx_bit(tx_bit), .cs_on(cs_on), .rx_in(rx_in));

  task stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Sync pulse count, data bit feed, hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (rx_out.sync_found)
      sync_cnt <= sync_cnt + 1;
    if (tx_data_take)
    begin
      bi      <= bi + 1;
      tx_data <= (bi < 55) ? stream[54 - bi] : 1'b0;
    end
    if (cycles == 60000)
    begin
      fail_count++;
      stop_test();
    end
  end

  task axi_wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {24'h0, v};
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task axi_rd(input logic [5:0] a);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Header, first byte, then a sync copy with nerr flipped bits after restart
  task frame(input logic [2:0] mode, input int nerr, input int hit);
    logic [31:0] m;
    logic [31:0] pat;
    logic [7:0]  g;
    int          p;
    int          base;
    g = $random(seed);
    p = $unsigned($random(seed)) % 16;
    m = '0;
    for (int k = 0; k < nerr; k++)
      m[16 + (p + 5 * k) % 16] = 1'b1;
    pat = (mode == 3'd3) ? {2{RST_SYNC_H, RST_SYNC_L}} : {RST_SYNC_H, RST_SYNC_L, 16'h0};
    axi_wr(OFF_MODEM_CFG_B, {5'h0, mode});
    @(posedge clk);
    stream     <= {g, 8'h00, pat ^ m, 8'h00};
    tx_data    <= g[7];
    bi         <= 0;
    rx_restart <= 1'b1;
    @(posedge clk);
    rx_restart <= 1'b0;
    tx_start   <= 1'b1;
    base = sync_cnt;
    wait (sync_cnt == base + 1);
    @(posedge rx_out.byte_valid);
    #1;
    `CHK(rx_out.rx_byte, g)
    @(posedge clk);
    rx_restart <= 1'b1;
    @(posedge clk);
    rx_restart <= 1'b0;
    base = sync_cnt;
    wait (bi == 56);
    @(posedge clk);
    tx_start <= 1'b0;
    repeat (12) @(posedge rx_out.bit_valid);
    #1;
    `CHK(sync_cnt - base, hit)
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    foreach (offs[i])
    begin
      axi_rd(offs[i]);
      `CHK(d, {24'h0, rstv[i]})
    end
    axi_wr(OFF_MODEM_CFG_D, 8'h8E);
    trim = $random(seed);
    axi_wr(OFF_SYNTH_LOW, trim);
    repeat (2) @(posedge clk);
    `CHK(synth_offset, trim)
    axi_wr(OFF_FREQ_EST, trim);
    `CHK(r, RESP_SLV)
    axi_wr(OFF_MODEM_CFG_B, {1'b0, MOD_OOK, 4'h2});
    axi_rd(OFF_FREQ_EST);
    `CHK(r, RESP_OKAY)
    est0 = d;
    repeat (100) @(posedge clk);
    axi_rd(OFF_FREQ_EST);
    `CHK(d, est0)
    cs_on <= 1'b0;
    axi_wr(OFF_OFFSET_CFG, RST_OCC | 8'h20);
    axi_wr(OFF_MODEM_CFG_B, RST_CFG_B);
    axi_rd(OFF_FREQ_EST);
    est0 = d;
    repeat (100) @(posedge clk);
    axi_rd(OFF_FREQ_EST);
    `CHK(d, est0)
    cs_on <= 1'b1;
    repeat (100) @(posedge clk);
    axi_rd(OFF_FREQ_EST);
    `CHK(d != est0, 1'b1)
    axi_rd(6'h3C);
    `CHK({r, d}, {RESP_SLV, 32'h0})
    frame(3'd2, 0, 1);
    frame(3'd2, 1, 0);
    frame(3'd1, 1, 1);
    frame(3'd1, 2, 0);
    frame(3'd3, 2, 1);
    frame(3'd3, 3, 0);
    stop_test();
  end
endmodule
